//--- hdl/rds_map.svh
/*
  Constants for the redundant demand selector: encodings, defaults, limits, timing.
  Assumes demand values in tenths of a percent (0 to 1000) and a 40 ns clock.
*/
`ifndef RDS_MAP_SVH
`define RDS_MAP_SVH

`define RDS_SRC_PWM        2'h0
`define RDS_SRC_ANA        2'h1
`define RDS_SRC_CAN        2'h2

`define RDS_SD_MIN         2'h0
`define RDS_SD_MAX         2'h1
`define RDS_SD_LIMP        2'h2

`define RDS_PCT_MIN        10'h000
`define RDS_PCT_FULL       10'h3e8
`define RDS_FAILBACK_DEF   10'h032
`define RDS_TRACK_MAX_DEF  10'h064

`define RDS_DELAY_DEF_MS   14'h03e8
`define RDS_DELAY_MAX_MS   14'h2710

`define RDS_CUT_MIN_HZ     5'h01
`define RDS_CUT_MAX_HZ     5'h14
`define RDS_CUT_DEF_HZ     5'h14
// Filter gain per hertz at a 1 ms update, Q16 of 2*pi/1000
`define RDS_ALPHA_PER_HZ   14'h019c
`define RDS_FRAC_BITS      16

`define RDS_CLK_NS         40
`define RDS_MS_NS          1000000

`endif

//--- hdl/rds_pkg.sv
/*
  Types for the redundant demand selector.
  Assumes rds_map.svh is on the include path.
*/
`include "rds_map.svh"

package rds_pkg;

  typedef enum logic [1:0] {
    SRC_PWM = `RDS_SRC_PWM,
    SRC_ANA = `RDS_SRC_ANA,
    SRC_CAN = `RDS_SRC_CAN
  } rds_src_t;

  typedef enum logic [1:0] {
    SD_MIN  = `RDS_SD_MIN,
    SD_MAX  = `RDS_SD_MAX,
    SD_LIMP = `RDS_SD_LIMP
  } rds_sd_t;

  // Gray order: primary -> backup -> primary
  typedef enum logic {
    CTRL_PRI = 1'b0,
    CTRL_BAK = 1'b1
  } rds_ctrl_t;

endpackage : rds_pkg

//--- hdl/rds_selector.sv
/*
  Position demand front end: source selection, redundancy tracking, failover,
  low-pass filter, opening direction and shutdown target.
  Assumes all inputs come from logic on ref_clk, demands already scaled to
  tenths of a percent, and per-source fault flags from the input scalers.
*/
`timescale 1ns/100ps
`include "rds_map.svh"

module rds_selector #(
  parameter bit REDUNDANT_FW = 1'b1,
  parameter bit LIMP_OK      = 1'b1,
  parameter int TICK_CYC     = `RDS_MS_NS / `RDS_CLK_NS
) (
  input  logic              ref_clk,
  input  logic              reset_n,
  input  rds_pkg::rds_src_t cfg_primary_src,
  input  rds_pkg::rds_src_t cfg_backup_src,
  input  rds_pkg::rds_src_t cfg_input_src,
  input  logic              cfg_redundant,
  input  logic              cfg_track_en,
  input  logic              cfg_switch_backup,
  input  logic              cfg_filter_en,
  input  logic              cfg_dir_ccw,
  input  rds_pkg::rds_sd_t  cfg_shutdown_sel,
  input  logic [9:0]        cfg_failback,
  input  logic [9:0]        cfg_track_max,
  input  logic [13:0]       cfg_track_delay_ms,
  input  logic [4:0]        cfg_cutoff_hz,
  input  logic [9:0]        pwm_demand,
  input  logic [9:0]        ana_demand,
  input  logic [9:0]        can_demand,
  input  logic              pwm_fault,
  input  logic              ana_fault,
  input  logic              can_fault,
  input  logic              shutdown,
  output logic [9:0]        pos_demand_r,
  output logic              drive_en_r,
  output logic              shaft_ccw_r,
  output logic              track_fault_r,
  output logic              primary_failed_r,
  output logic              backup_failed_r,
  output logic              backup_active_r,
  output logic [9:0]        failback_r,
  output logic [9:0]        track_max_r,
  output logic [13:0]       track_delay_r,
  output logic [4:0]        cutoff_r
);
  import rds_pkg::*;

  logic        rst_meta_r;
  logic        rst_n_r;
  logic [15:0] tick_cnt_r;
  logic [13:0] over_cnt_r;
  rds_ctrl_t   ctrl_r;
  rds_ctrl_t   ctrl_nxt;
  logic [25:0] filt_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Source selection; an unused encoding falls back to PWM
  wire rds_src_t pri_src = REDUNDANT_FW ? cfg_primary_src : cfg_input_src;
  wire rds_src_t bak_src = cfg_backup_src;
  wire       redundant = REDUNDANT_FW && cfg_redundant;
  wire [9:0] pri_dem   = (pri_src == SRC_ANA) ? ana_demand :
                         (pri_src == SRC_CAN) ? can_demand : pwm_demand;
  wire [9:0] bak_dem   = (bak_src == SRC_ANA) ? ana_demand :
                         (bak_src == SRC_CAN) ? can_demand : pwm_demand;
  wire       pri_src_f = (pri_src == SRC_ANA) ? ana_fault :
                         (pri_src == SRC_CAN) ? can_fault : pwm_fault;
  wire       bak_src_f = (bak_src == SRC_ANA) ? ana_fault :
                         (bak_src == SRC_CAN) ? can_fault : pwm_fault;
  wire [9:0] deviation = (pri_dem > bak_dem) ? pri_dem - bak_dem : bak_dem - pri_dem;

  // Settings outside their range are ignored and the last accepted value stays
  wire       fb_ok     = (cfg_failback <= `RDS_PCT_FULL) && (cfg_failback < track_max_r);
  wire [9:0] fb_nxt    = fb_ok ? cfg_failback : failback_r;
  wire       tm_ok     = (cfg_track_max <= `RDS_PCT_FULL) && (cfg_track_max > fb_nxt);
  wire       dly_ok    = cfg_track_delay_ms <= `RDS_DELAY_MAX_MS;
  wire       cut_ok    = (cfg_cutoff_hz >= `RDS_CUT_MIN_HZ) &&
                         (cfg_cutoff_hz <= `RDS_CUT_MAX_HZ);

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      failback_r    <= `RDS_FAILBACK_DEF;
      track_max_r   <= `RDS_TRACK_MAX_DEF;
      track_delay_r <= `RDS_DELAY_DEF_MS;
      cutoff_r      <= `RDS_CUT_DEF_HZ;
    end else begin
      failback_r    <= fb_nxt;
      track_max_r   <= tm_ok ? cfg_track_max : track_max_r;
      track_delay_r <= dly_ok ? cfg_track_delay_ms : track_delay_r;
      cutoff_r      <= cut_ok ? cfg_cutoff_hz : cutoff_r;
    end
  end

  // Millisecond time base for the tracking delay and the filter update
  wire tick = tick_cnt_r == 16'(TICK_CYC - 1);

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    end
  end

  // Tracking check; only an unbroken excess counts toward the delay
  wire track_on  = redundant && cfg_track_en;
  wire over      = track_on && (deviation > track_max_r);
  wire delay_hit = over_cnt_r >= track_delay_r;
  wire cnt_sat   = over_cnt_r == `RDS_DELAY_MAX_MS;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      over_cnt_r    <= 14'h0000;
      track_fault_r <= 1'b0;
    end else begin
      if (!over) begin
        over_cnt_r <= 14'h0000;
      end else if (tick && !cnt_sat) begin
        over_cnt_r <= over_cnt_r + 14'h0001;
      end
      track_fault_r <= over && delay_hit;
    end
  end

  // Failure marks and which input is in control
  wire trk_pri_f  = track_fault_r && cfg_switch_backup;
  wire trk_bak_f  = track_fault_r && !cfg_switch_backup;
  wire pri_failed = pri_src_f || trk_pri_f;
  wire bak_failed = redundant && (bak_src_f || trk_bak_f);
  wire fb_close   = deviation <= failback_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    case (ctrl_r)
      CTRL_PRI: begin
        if (redundant && pri_failed && !bak_failed) begin
          ctrl_nxt = CTRL_BAK;
        end
      end
      CTRL_BAK: begin
        if (!redundant || bak_failed) begin
          ctrl_nxt = CTRL_PRI;
        end else if (!pri_failed && fb_close) begin
          ctrl_nxt = CTRL_PRI;
        end
      end
      default: ctrl_nxt = CTRL_PRI;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r           <= CTRL_PRI;
      primary_failed_r <= 1'b0;
      backup_failed_r  <= 1'b0;
      backup_active_r  <= 1'b0;
    end else begin
      ctrl_r           <= ctrl_nxt;
      primary_failed_r <= pri_failed;
      backup_failed_r  <= bak_failed;
      backup_active_r  <= ctrl_nxt == CTRL_BAK;
    end
  end

  wire [9:0] sel_dem = (ctrl_r == CTRL_BAK) ? bak_dem : pri_dem;

  // First-order low-pass, updated once a millisecond
  wire        [13:0] alpha  = {9'h000, cutoff_r} * `RDS_ALPHA_PER_HZ;
  wire        [25:0] x_q    = {sel_dem, 16'h0000};
  wire signed [26:0] err    = $signed({1'b0, x_q}) - $signed({1'b0, filt_r});
  wire signed [41:0] prod   = err * $signed({1'b0, alpha});
  wire signed [26:0] f_sum  = $signed({1'b0, filt_r}) + prod[41:`RDS_FRAC_BITS];
  wire        [9:0]  filt_q = filt_r[25:`RDS_FRAC_BITS];

  // Filter tracks the input while off so switching it on causes no jump
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      filt_r <= 26'h0000000;
    end else if (!cfg_filter_en) begin
      filt_r <= x_q;
    end else if (tick) begin
      filt_r <= f_sum[25:0];
    end
  end

  // Output stage: shutdown target overrides the demand
  wire       limp    = shutdown && LIMP_OK && (cfg_shutdown_sel == SD_LIMP);
  wire [9:0] run_dem = cfg_filter_en ? filt_q : sel_dem;
  wire [9:0] sd_dem  = (cfg_shutdown_sel == SD_MAX) ? `RDS_PCT_FULL : `RDS_PCT_MIN;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pos_demand_r <= `RDS_PCT_MIN;
      drive_en_r   <= 1'b0;
      shaft_ccw_r  <= 1'b0;
    end else begin
      pos_demand_r <= shutdown ? sd_dem : run_dem;
      drive_en_r   <= !limp;
      shaft_ccw_r  <= cfg_dir_ccw;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  single_uses_primary_a: assert property (
    !redundant |=> ctrl_r == CTRL_PRI)
    else $error("Backup in control while in single-input mode");

  fault_needs_excess_a: assert property (
    !over |=> !track_fault_r)
    else $error("Tracking fault without a preceding excess");

  fault_after_delay_a: assert property (
    over && delay_hit |=> track_fault_r)
    else $error("Tracking fault missing after delay elapsed");

  switch_marks_primary_a: assert property (
    track_fault_r && cfg_switch_backup |=> primary_failed_r)
    else $error("Primary not marked failed on tracking fault");

  keep_marks_backup_a: assert property (
    track_fault_r && !cfg_switch_backup && redundant |=> backup_failed_r
      && primary_failed_r == $past(pri_src_f))
    else $error("Backup not marked failed on tracking fault");

  limit_order_a: assert property (
    track_max_r > failback_r && track_max_r <= `RDS_PCT_FULL)
    else $error("Tracking maximum not above failback limit");

  failback_close_a: assert property (
    ctrl_r == CTRL_BAK && redundant && !bak_failed ##1 ctrl_r == CTRL_PRI |-> $past(fb_close))
    else $error("Return to primary with demands too far apart");

  delay_range_a: assert property (
    track_delay_r <= `RDS_DELAY_MAX_MS && cutoff_r >= `RDS_CUT_MIN_HZ
      && cutoff_r <= `RDS_CUT_MAX_HZ)
    else $error("Accepted delay or cut-off out of range");

  shutdown_target_a: assert property (
    shutdown && cfg_shutdown_sel == SD_MIN |=> pos_demand_r == `RDS_PCT_MIN)
    else $error("Shutdown to minimum not applied");

  unfiltered_path_a: assert property (
    !shutdown && !cfg_filter_en |=> pos_demand_r == $past(sel_dem))
    else $error("Unfiltered demand not passed through");

  shutdown_max_a: assert property (
    shutdown && cfg_shutdown_sel == SD_MAX |=> pos_demand_r == `RDS_PCT_FULL)
    else $error("Shutdown to maximum not applied");

  limp_drive_a: assert property (
    shutdown && cfg_shutdown_sel == SD_LIMP |=> drive_en_r == !LIMP_OK)
    else $error("Limp request handled wrongly");

  backup_demand_a: assert property (
    ctrl_r == CTRL_BAK && !shutdown && !cfg_filter_en |=> pos_demand_r == $past(bak_dem))
    else $error("Backup in control but its demand not used");

  direction_copy_a: assert property (
    1'b1 |=> shaft_ccw_r == $past(cfg_dir_ccw))
    else $error("Opening direction not applied");

  timer_restart_a: assert property (
    !over |=> over_cnt_r == 14'h0000)
    else $error("Tracking timer not restarted");

  failover_c: cover property (ctrl_r == CTRL_PRI ##1 ctrl_r == CTRL_BAK);
  failback_c: cover property (ctrl_r == CTRL_BAK ##1 ctrl_r == CTRL_PRI);
  track_fault_c: cover property ($rose(track_fault_r));
  limp_c: cover property (!drive_en_r ##1 drive_en_r);
  filter_step_c: cover property (cfg_filter_en && tick && filt_q != sel_dem);

endmodule : rds_selector

//--- test/rds_ecu_model.sv
/*
  Engine control model: drives the three scaled demands and their fault flags.
  Assumes the bench calls put just after a falling clock edge.
*/
`timescale 1ns/100ps

module rds_ecu_model (
  output logic [9:0] pwm_demand,
  output logic [9:0] ana_demand,
  output logic [9:0] can_demand,
  output logic       pwm_fault,
  output logic       ana_fault,
  output logic       can_fault
);
  initial begin
    {pwm_demand, ana_demand, can_demand} = '0;
    {pwm_fault, ana_fault, can_fault} = '0;
  end

  // Index 0 pulse-width, 1 analog, 2 CAN
  task put(input int i, input logic [9:0] v, input logic f);
    case (i)
      0: begin pwm_demand = v; pwm_fault = f; end
      1: begin ana_demand = v; ana_fault = f; end
      default: begin can_demand = v; can_fault = f; end
    endcase
  endtask : put
endmodule : rds_ecu_model

//--- test/redundant_demand_selector_bench.sv
/*
  Self-checking bench for the demand selector, partner model on the demand side.
  Assumes a short tick (4 cycles per ms) so tracking delays stay brief.
*/
`timescale 1ns/100ps

module redundant_demand_selector_bench;
  import rds_pkg::*;
  logic        ref_clk, reset_n, red, trk, swb, fen, ccw, sd, drv, sccw, tf, pf, bf, ba;
  rds_src_t    ps, bs;
  rds_sd_t     sds;
  logic [9:0]  fb, tm, pd, ad, cd, pos, fbr, tmr;
  logic [13:0] dl, tdl;
  logic [4:0]  co, cut;
  logic        pf_i, af_i, cf_i;
  rds_src_t    isrc;
  logic [9:0]  pos_nr;
  logic        drv_nr;
  int          errors, check_count, n;

  rds_ecu_model rds_ecu_model_inst (.pwm_demand(pd), .ana_demand(ad), .can_demand(cd),
    .pwm_fault(pf_i), .ana_fault(af_i), .can_fault(cf_i));

  rds_selector #(.TICK_CYC(4)) rds_selector_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfg_primary_src(ps), .cfg_backup_src(bs), .cfg_input_src(isrc),
    .cfg_redundant(red), .cfg_track_en(trk), .cfg_switch_backup(swb), .cfg_filter_en(fen),
    .cfg_dir_ccw(ccw), .cfg_shutdown_sel(sds), .cfg_failback(fb), .cfg_track_max(tm),
    .cfg_track_delay_ms(dl), .cfg_cutoff_hz(co), .pwm_demand(pd), .ana_demand(ad),
    .can_demand(cd), .pwm_fault(pf_i), .ana_fault(af_i), .can_fault(cf_i), .shutdown(sd),
    .pos_demand_r(pos), .drive_en_r(drv), .shaft_ccw_r(sccw), .track_fault_r(tf),
    .primary_failed_r(pf), .backup_failed_r(bf), .backup_active_r(ba), .failback_r(fbr),
    .track_max_r(tmr), .track_delay_r(tdl), .cutoff_r(cut));

  // Non-redundant variant without limp support, sharing all stimulus
  if (1) begin : single_fw
    rds_selector #(.REDUNDANT_FW(1'b0), .LIMP_OK(1'b0), .TICK_CYC(4)) rds_selector_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .cfg_primary_src(ps), .cfg_backup_src(bs),
      .cfg_input_src(isrc), .cfg_redundant(red), .cfg_track_en(trk), .cfg_switch_backup(swb),
      .cfg_filter_en(fen), .cfg_dir_ccw(ccw), .cfg_shutdown_sel(sds), .cfg_failback(fb),
      .cfg_track_max(tm), .cfg_track_delay_ms(dl), .cfg_cutoff_hz(co), .pwm_demand(pd),
      .ana_demand(ad), .can_demand(cd), .pwm_fault(pf_i), .ana_fault(af_i), .can_fault(cf_i),
      .shutdown(sd), .pos_demand_r(pos_nr), .drive_en_r(drv_nr), .shaft_ccw_r(),
      .track_fault_r(), .primary_failed_r(), .backup_failed_r(), .backup_active_r(),
      .failback_r(), .track_max_r(), .track_delay_r(), .cutoff_r());
  end

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc

  task automatic put(input int i, input logic [9:0] v, input logic f);
    rds_ecu_model_inst.put(i, v, f);
  endtask : put

  task end_sim;
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // Settings land one cycle later; refused ones keep the old value
  task automatic cfg(input logic [9:0] a, b, input logic [13:0] c, input logic [4:0] d,
                     input logic [9:0] ea, eb, input logic [13:0] ec, input logic [4:0] ed);
    fb = a; tm = b; dl = c; co = d;
    cyc(1);
    chk(fbr, ea);
    chk(tmr, eb);
    chk(tdl, ec);
    chk(cut, ed);
  endtask : cfg

  // Bounded wait; a hang ends the run
  task automatic wait_tf;
    for (n = 0; n < 40 && tf !== 1'b1; n++) cyc(1);
    chk(tf, 1'b1);
    if (tf !== 1'b1) end_sim;
  endtask : wait_tf

  initial begin
    {reset_n, red, trk, swb, fen, ccw, sd} = '0;
    ps = SRC_PWM; bs = SRC_PWM; sds = SD_MIN; isrc = SRC_PWM;
    fb = 10'h032; tm = 10'h064; dl = 14'h03e8; co = 5'h14;
    errors = 0; check_count = 0;
    cyc(8);
    chk({pos, drv, fbr}, 21'h000032);
    chk(tmr, 10'h064);
    chk(tdl, 14'h03e8);
    chk(cut, 5'h14);
    reset_n = 1'b1;
    cyc(4);
    put(0, 10'h064, 1'b0); put(1, 10'h0c8, 1'b0); put(2, 10'h12c, 1'b0);
    for (n = 0; n < 3; n++) begin
      ps = rds_src_t'(n);
      isrc = rds_src_t'(2 - n);
      cyc(1);
      chk({drv, pos}, 14'(11'h400 + 100 * (n + 1)));
      chk({drv_nr, pos_nr}, 14'(11'h400 + 100 * (3 - n)));
    end
    ccw = 1'b1; cyc(1); chk(sccw, 1'b1);
    sd = 1'b1;
    for (n = 0; n < 3; n++) begin
      sds = rds_sd_t'(n);
      cyc(1);
      chk({drv, pos}, (n == 2) ? 14'h0 : (n == 1) ? 14'h7e8 : 14'h400);
      chk({drv_nr, pos_nr}, (n == 1) ? 14'h7e8 : 14'h400);
    end
    sd = 1'b0;
    cfg(10'h032, 10'h0c8, 14'h2710, 5'h01, 10'h032, 10'h0c8, 14'h2710, 5'h01);
    cfg(10'h0c8, 10'h3e9, 14'h2711, 5'h00, 10'h032, 10'h0c8, 14'h2710, 5'h01);
    cfg(10'h096, 10'h096, 14'h0000, 5'h15, 10'h096, 10'h0c8, 14'h0000, 5'h01);
    cfg(10'h032, 10'h064, 14'h0002, 5'h14, 10'h032, 10'h064, 14'h0002, 5'h14);
    // Faulted primary rotates through sources; backup follows each code
    for (n = 0; n < 3; n++) begin
      red = 1'b0; ps = rds_src_t'((n + 1) % 3); bs = rds_src_t'(n);
      put((n + 1) % 3, 10'(100 * ((n + 1) % 3 + 1)), 1'b1);
      cyc(1);
      red = 1'b1;
      cyc(3);
      chk({pf, ba, pos}, 14'(12'hc00 + 100 * (n + 1)));
      put((n + 1) % 3, 10'(100 * ((n + 1) % 3 + 1)), 1'b0);
      cyc(3);
      chk(ba, 1'b1);
    end
    red = 1'b0; ps = SRC_PWM; bs = SRC_ANA;
    put(0, 10'h1f4, 1'b0); put(1, 10'h2bc, 1'b0);
    cyc(1); red = 1'b1; cyc(20); chk(tf, 1'b0);
    trk = 1'b1; cyc(3); chk(tf, 1'b0);
    wait_tf;
    // Failure marks follow the fault by one clock
    cyc(1); chk({pf, bf, pos}, 14'h5f4);
    put(1, 10'h244, 1'b0); cyc(2); chk(tf, 1'b0);
    put(1, 10'h2bc, 1'b0); cyc(3); chk(tf, 1'b0);
    swb = 1'b1;
    wait_tf;
    cyc(2); chk({pf, ba, pos}, 14'hebc);
    put(1, 10'h244, 1'b0); cyc(4); chk({tf, ba}, 2'h1);
    put(1, 10'h21c, 1'b0); cyc(4); chk({ba, pos}, 11'h1f4);
    red = 1'b0; fen = 1'b1; cyc(2); chk(pos, 10'h1f4);
    put(0, 10'h3e8, 1'b0); cyc(2); chk(pos < 10'h3e8, 1'b1);
    cyc(8); chk(pos > 10'h1f4 && pos < 10'h3e8, 1'b1);
    end_sim;
  end
endmodule : redundant_demand_selector_bench
